/* rtl/ext_irq_pkg.sv */
// constants and types shared by the external pin interrupt unit
package ext_irq_pkg;

	localparam int unsigned NUM_LINES   = 2;
	localparam int unsigned NUM_PINS    = 24;
	localparam int unsigned NUM_VEC     = 5;
	localparam int unsigned ADDR_W      = 12;
	localparam int unsigned SYNC_STAGES = 2;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_EXT_FLAG      = 8'h1C;
	localparam logic [7:0] IDX_LINE_ENABLE   = 8'h1D;
	localparam logic [7:0] IDX_GROUP_FLAG    = 8'h1B;
	localparam logic [7:0] IDX_GROUP_ENABLE  = 8'h68;
	localparam logic [7:0] IDX_SENSE_CONFIG  = 8'h69;
	localparam logic [7:0] IDX_MASK_LO       = 8'h6B;
	localparam logic [7:0] IDX_MASK_MID      = 8'h6C;
	localparam logic [7:0] IDX_MASK_HI       = 8'h6D;

	localparam logic [ADDR_W-1:0] ADDR_EXT_FLAG     = {2'h0, IDX_EXT_FLAG, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_LINE_ENABLE  = {2'h0, IDX_LINE_ENABLE, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_GROUP_FLAG   = {2'h0, IDX_GROUP_FLAG, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_GROUP_ENABLE = {2'h0, IDX_GROUP_ENABLE, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_SENSE_CONFIG = {2'h0, IDX_SENSE_CONFIG, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_MASK_LO      = {2'h0, IDX_MASK_LO, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_MASK_MID     = {2'h0, IDX_MASK_MID, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_MASK_HI      = {2'h0, IDX_MASK_HI, 2'h0};

	// field positions
	localparam int unsigned LINE_A_BIT   = 0;
	localparam int unsigned LINE_B_BIT   = 1;
	localparam int unsigned SENSE_A_POS  = 0;
	localparam int unsigned SENSE_B_POS  = 2;
	localparam int unsigned GROUP_LO_POS = 0;
	localparam int unsigned GROUP_MID_POS = 8;
	localparam int unsigned GROUP_HI_POS = 16;

	// sense encodings
	localparam logic [1:0] SENSE_LOW_LEVEL = 2'h0;
	localparam logic [1:0] SENSE_ANY_EDGE  = 2'h1;
	localparam logic [1:0] SENSE_FALLING   = 2'h2;
	localparam logic [1:0] SENSE_RISING    = 2'h3;

	// vector slots
	localparam int unsigned VEC_LINE_A    = 0;
	localparam int unsigned VEC_LINE_B    = 1;
	localparam int unsigned VEC_GROUP_LO  = 2;
	localparam int unsigned VEC_GROUP_MID = 3;
	localparam int unsigned VEC_GROUP_HI  = 4;

	// reset values
	localparam logic [1:0]  RST_LINE_ENABLE  = 2'h0;
	localparam logic [3:0]  RST_SENSE_CONFIG = 4'h0;
	localparam logic [2:0]  RST_GROUP_ENABLE = 3'h0;
	localparam logic [7:0]  RST_MASK_LO      = 8'h00;
	localparam logic [6:0]  RST_MASK_MID     = 7'h00;
	localparam logic [7:0]  RST_MASK_HI      = 8'h00;
	localparam logic [1:0]  RST_EXT_FLAG     = 2'h0;
	localparam logic [2:0]  RST_GROUP_FLAG   = 3'h0;
	localparam logic [1:0]  RST_RESET_SYNC   = 2'h0;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} apb_req_s;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} apb_rsp_s;

	typedef struct packed {
		logic [1:0]          lineEnable;
		logic [3:0]          senseConfig;
		logic [2:0]          groupEnable;
		logic [7:0]          maskLo;
		logic [6:0]          maskMid;
		logic [7:0]          maskHi;
		logic [1:0]          extFlag;
		logic [2:0]          groupFlag;
		logic [1:0]          linePrev;
		logic [NUM_PINS-1:0] pinPrev;
		logic [NUM_VEC-1:0]  irqReq;
		logic [NUM_VEC-1:0]  vecAck;
		logic                wake;
		apb_rsp_s            rsp;
	} state_s;

endpackage

/* rtl/pin_sync.sv */
// two-stage synchroniser for a group of pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_s;

	sync_s syncState_q;
	sync_s syncState_d;

	// first stage feeds only the second
	always_comb begin
		syncState_d.stage1 = din;
		syncState_d.stage2 = syncState_q.stage1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			syncState_q <= '0;
		end else begin
			syncState_q <= syncState_d;
		end
	end

	assign dout = syncState_q.stage2;
endmodule // pin_sync
`default_nettype wire

/* rtl/external_pin_interrupt_unit.sv */
// external pin interrupt unit: two sensed lines, 24 pin-change inputs, apb registers
//
// Overview of operation
// - unmasked change on inputs 23..16 raises high group
// - unmasked change on inputs 14..8 raises mid group
// - unmasked change on inputs 7..0 raises low group
// - pins sensed even when driven as outputs
// - per-pin masks gate each group contribution
// - pin-change detection usable for wake from sleep
// - low-level mode requests while pin stays low
// - edge detection needs the running i/o clock
// - low-level detection usable for wake from sleep
// - wake level must outlast start-up for interrupt
// - line b sense: low, any, falling, rising
// - line a sense uses same encoding
// - pins sampled before edge compare
// - line taken only with global and own enable
// - enable register: bit1 line b, bit0 line a
// - reserved bits of sense/enable read zero
// - sense bits 3:2 line b, 1:0 line a
// - every line and group has its own vector
// - line flag set by edge, cleared by vector/w1c
// - group enable plus global flag gates group
// - group flag set on change, cleared vector/w1c
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module external_pin_interrupt_unit
	import ext_irq_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                nrst,
	input  wire apb_req_s            apbReq,
	output apb_rsp_s                 apbRsp,
	input  wire logic                extLineA,
	input  wire logic                extLineB,
	input  wire logic [NUM_PINS-1:0] pinChangeInputs,
	input  wire logic                globalIntEnable,
	input  wire logic [NUM_VEC-1:0]  vectorTake,
	output logic      [NUM_VEC-1:0]  irqRequest,
	output logic      [NUM_VEC-1:0]  vectorAck,
	output logic                     wakeRequest
);

	logic [1:0]          rstSync_q;
	logic                rstSync_n;
	logic [NUM_LINES-1:0] lineSync;
	logic [NUM_PINS-1:0] pinSync;
	state_s              state_q;
	state_s              state_d;

	// reset release through two flops
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rstSync_q <= RST_RESET_SYNC;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end

	assign rstSync_n = rstSync_q[1];

	// dedicated lines, sampled regardless of pin direction
	pin_sync #(
		.WIDTH (NUM_LINES)
	) u_line_sync (
		.clk   (ref_clk),
		.rst_n (rstSync_n),
		.din   ({extLineB, extLineA}),
		.dout  (lineSync)
	);

	// pin-change inputs, sampled regardless of pin direction
	pin_sync #(
		.WIDTH (NUM_PINS)
	) u_pin_sync (
		.clk   (ref_clk),
		.rst_n (rstSync_n),
		.din   (pinChangeInputs),
		.dout  (pinSync)
	);

	// trigger decode for one line
	function automatic logic line_trigger(
		input logic [1:0] sense,
		input logic       cur,
		input logic       prev
	);
		logic hit;
		hit = 1'b0;
		case (sense)
			SENSE_ANY_EDGE: hit = cur ^ prev;
			SENSE_FALLING:  hit = prev & ~cur;
			SENSE_RISING:   hit = cur & ~prev;
			default:        hit = 1'b0;
		endcase
		return hit;
	endfunction

	logic                 apbSetup;
	logic                 apbWrite;
	logic [7:0]           wrByte;
	logic [NUM_LINES-1:0] lineEdge;
	logic [NUM_LINES-1:0] lineLow;
	logic [NUM_LINES-1:0] levelMode;
	logic [NUM_LINES-1:0] lineClear;
	logic [NUM_PINS-1:0]  pinChange;
	logic [NUM_PINS-1:0]  pinMask;
	logic [2:0]           groupSet;
	logic [2:0]           groupClear;
	logic [NUM_VEC-1:0]   pending;
	logic [NUM_VEC-1:0]   enabled;
	logic [31:0]          rdData;
	logic                 rdHit;

	always_comb begin
		state_d = state_q;

		apbSetup = apbReq.psel & ~apbReq.penable;
		apbWrite = apbReq.psel & apbReq.penable & state_q.rsp.pready & apbReq.pwrite;
		wrByte   = apbReq.pwdata[7:0];

		// per-line edge and level detection
		for (int i = 0; i < NUM_LINES; i++) begin
			levelMode[i] = (state_q.senseConfig[2*i +: 2] == SENSE_LOW_LEVEL);
			lineLow[i]   = ~lineSync[i];
			lineEdge[i]  = line_trigger(state_q.senseConfig[2*i +: 2],
				lineSync[i], state_q.linePrev[i]);
		end
		state_d.linePrev = lineSync;

		// pin-change masks and group collection
		pinMask   = {state_q.maskHi, 1'b0, state_q.maskMid, state_q.maskLo};
		pinChange = (pinSync ^ state_q.pinPrev) & pinMask;
		groupSet[0] = |pinChange[GROUP_LO_POS +: 8];
		groupSet[1] = |pinChange[GROUP_MID_POS +: 7];
		groupSet[2] = |pinChange[GROUP_HI_POS +: 8];
		state_d.pinPrev = pinSync;

		// flag clears from software write-one and from vector take
		lineClear  = '0;
		groupClear = '0;
		if (apbWrite && apbReq.paddr == ADDR_EXT_FLAG) begin
			lineClear = wrByte[1:0];
		end
		if (apbWrite && apbReq.paddr == ADDR_GROUP_FLAG) begin
			groupClear = wrByte[2:0];
		end
		lineClear[LINE_A_BIT]  = lineClear[LINE_A_BIT] | vectorTake[VEC_LINE_A];
		lineClear[LINE_B_BIT]  = lineClear[LINE_B_BIT] | vectorTake[VEC_LINE_B];
		groupClear[0] = groupClear[0] | vectorTake[VEC_GROUP_LO];
		groupClear[1] = groupClear[1] | vectorTake[VEC_GROUP_MID];
		groupClear[2] = groupClear[2] | vectorTake[VEC_GROUP_HI];

		// set wins over clear; flag held clear in level mode
		for (int i = 0; i < NUM_LINES; i++) begin
			state_d.extFlag[i] = ((state_q.extFlag[i] & ~lineClear[i]) | lineEdge[i])
				& ~levelMode[i];
		end
		state_d.groupFlag = (state_q.groupFlag & ~groupClear) | groupSet;

		// pending sources per vector
		pending[VEC_LINE_A] = levelMode[LINE_A_BIT] ? lineLow[LINE_A_BIT]
			: state_q.extFlag[LINE_A_BIT];
		pending[VEC_LINE_B] = levelMode[LINE_B_BIT] ? lineLow[LINE_B_BIT]
			: state_q.extFlag[LINE_B_BIT];
		pending[VEC_GROUP_HI:VEC_GROUP_LO] = state_q.groupFlag;

		enabled[VEC_LINE_A] = state_q.lineEnable[LINE_A_BIT];
		enabled[VEC_LINE_B] = state_q.lineEnable[LINE_B_BIT];
		enabled[VEC_GROUP_HI:VEC_GROUP_LO] = state_q.groupEnable;

		// one request line per vector, gated by the global flag
		state_d.irqReq = pending & enabled & {NUM_VEC{globalIntEnable}};
		state_d.vecAck = vectorTake & state_q.irqReq;

		// wake on any unmasked change in an enabled group or enabled low level
		state_d.wake = (|(pinChange & {{8{state_q.groupEnable[2]}}, {8{state_q.groupEnable[1]}},
			{8{state_q.groupEnable[0]}}}))
			| (|(levelMode & lineLow & state_q.lineEnable));

		// register writes
		if (apbWrite) begin
			case (apbReq.paddr)
				ADDR_LINE_ENABLE:  state_d.lineEnable  = wrByte[1:0];
				ADDR_SENSE_CONFIG: state_d.senseConfig = wrByte[3:0];
				ADDR_GROUP_ENABLE: state_d.groupEnable = wrByte[2:0];
				ADDR_MASK_LO:      state_d.maskLo      = wrByte;
				ADDR_MASK_MID:     state_d.maskMid     = wrByte[6:0];
				ADDR_MASK_HI:      state_d.maskHi      = wrByte;
				default:           state_d.maskLo      = state_q.maskLo;
			endcase
		end

		// read mux, reserved bits zero
		rdHit  = 1'b1;
		rdData = 32'h0000_0000;
		case (apbReq.paddr)
			ADDR_LINE_ENABLE:  rdData[1:0] = state_q.lineEnable;
			ADDR_SENSE_CONFIG: rdData[3:0] = state_q.senseConfig;
			ADDR_EXT_FLAG:     rdData[1:0] = state_q.extFlag;
			ADDR_GROUP_ENABLE: rdData[2:0] = state_q.groupEnable;
			ADDR_GROUP_FLAG:   rdData[2:0] = state_q.groupFlag;
			ADDR_MASK_LO:      rdData[7:0] = state_q.maskLo;
			ADDR_MASK_MID:     rdData[6:0] = state_q.maskMid;
			ADDR_MASK_HI:      rdData[7:0] = state_q.maskHi;
			default:           rdHit       = 1'b0;
		endcase

		// zero-wait answer: ready during the access phase only
		state_d.rsp.pready  = apbSetup;
		state_d.rsp.prdata  = (apbSetup && !apbReq.pwrite) ? rdData : 32'h0000_0000;
		state_d.rsp.pslverr = apbSetup & ~rdHit;
	end

	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			state_q             <= '0;
			state_q.lineEnable  <= RST_LINE_ENABLE;
			state_q.senseConfig <= RST_SENSE_CONFIG;
			state_q.groupEnable <= RST_GROUP_ENABLE;
			state_q.maskLo      <= RST_MASK_LO;
			state_q.maskMid     <= RST_MASK_MID;
			state_q.maskHi      <= RST_MASK_HI;
			state_q.extFlag     <= RST_EXT_FLAG;
			state_q.groupFlag   <= RST_GROUP_FLAG;
		end else begin
			state_q <= state_d;
		end
	end

	assign apbRsp      = state_q.rsp;
	assign irqRequest  = state_q.irqReq;
	assign vectorAck   = state_q.vecAck;
	assign wakeRequest = state_q.wake;

endmodule // external_pin_interrupt_unit
`default_nettype wire

/* bench/ext_irq_monitor.sv */
// assertion checker for the external pin interrupt unit
`timescale 1ns/1ns
`default_nettype none
module ext_irq_monitor
	import ext_irq_pkg::*;
(
	input wire logic               ref_clk,
	input wire logic               nrst,
	input wire apb_req_s           apbReq,
	input wire apb_rsp_s           apbRsp,
	input wire logic               globalIntEnable,
	input wire logic [NUM_VEC-1:0] vectorTake,
	input wire logic [NUM_VEC-1:0] irqRequest,
	input wire logic [NUM_VEC-1:0] vectorAck
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	a_ack_from_take: assert property (vectorAck == $past(vectorTake & irqRequest))
		else $error("ack not from take");
	a_global_gates: assert property (!globalIntEnable [*2] |-> irqRequest == '0)
		else $error("request while global off");
	a_group_holds: assert property (!vectorTake[4] && !apbReq.psel
		##1 irqRequest[4] && globalIntEnable |=> irqRequest[4])
		else $error("group request lost");
	a_enable_reserved: assert property (apbRsp.pready && apbReq.paddr == ADDR_LINE_ENABLE
		|-> apbRsp.prdata[31:2] == '0) else $error("enable reserved set");
	a_sense_reserved: assert property (apbRsp.pready && apbReq.paddr == ADDR_SENSE_CONFIG
		|-> apbRsp.prdata[31:4] == '0) else $error("sense reserved set");
	a_ready_once: assert property (apbReq.psel && !apbReq.penable |=> apbRsp.pready ##1 !apbRsp.pready)
		else $error("ready timing");
	a_err_in_access: assert property (apbRsp.pslverr |-> apbRsp.pready)
		else $error("error outside access");
	a_idle_data_zero: assert property (!apbRsp.pready |-> apbRsp.prdata == '0)
		else $error("data outside access");
endmodule // ext_irq_monitor
bind external_pin_interrupt_unit ext_irq_monitor ext_irq_monitor_i (.ref_clk(ref_clk), .nrst(nrst),
	.apbReq(apbReq), .apbRsp(apbRsp), .globalIntEnable(globalIntEnable),
	.vectorTake(vectorTake), .irqRequest(irqRequest), .vectorAck(vectorAck));
`default_nettype wire

/* bench/core_vector_model.sv */
// core side model: takes the lowest pending vector after a set delay
`timescale 1ns/1ns
`default_nettype none
module core_vector_model
	import ext_irq_pkg::*;
(
	input  wire logic               ref_clk,
	input  wire logic               nrst,
	input  wire logic               en,
	input  wire logic [7:0]         delay,
	input  wire logic [NUM_VEC-1:0] irqRequest,
	output logic      [NUM_VEC-1:0] vectorTake
);
	int cnt;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			vectorTake <= '0;
			cnt <= 0;
		end else begin
			vectorTake <= '0;
			if (en && irqRequest != '0 && cnt == int'(delay)) begin
				vectorTake <= irqRequest & (~irqRequest + 1'b1); // one-cycle take
				cnt <= -3;
			end else if (cnt < 0 || (en && irqRequest != '0))
				cnt <= cnt + 1;
			else
				cnt <= 0;
		end
	end
endmodule // core_vector_model
`default_nettype wire

/* bench/tb_external_pin_interrupt_unit.sv */
// self-checking bench for the external pin interrupt unit
`timescale 1ns/1ns
`default_nettype none
module tb_external_pin_interrupt_unit
	import ext_irq_pkg::*;
;
	logic                refClk = 1'b0;
	logic                nrst   = 1'b0;
	logic                gie    = 1'b0;
	logic                coreEn = 1'b0;
	logic                er, wake, ex;
	logic [1:0]          lines  = 2'h3;
	logic [7:0]          delay  = 8'h00;
	logic [7:0]          mk;
	logic [31:0]         v;
	logic [31:0]         seed   = 32'h000113F3;
	logic [NUM_PINS-1:0] pins   = '0;
	logic [NUM_VEC-1:0]  take, irq, ack;
	apb_req_s            req    = '0;
	apb_rsp_s            rsp;
	int                  nFail = 0, checkCount = 0, nAck = 0, nWake = 0, a0, w0, g, p;
	localparam logic [ADDR_W-1:0] MAP [8] = '{ADDR_EXT_FLAG, ADDR_LINE_ENABLE, ADDR_GROUP_FLAG,
		ADDR_GROUP_ENABLE, ADDR_SENSE_CONFIG, ADDR_MASK_LO, ADDR_MASK_MID, ADDR_MASK_HI};
	localparam logic [7:0] RW [8] = '{8'h00, 8'h03, 8'h00, 8'h07, 8'h0F, 8'hFF, 8'h7F, 8'hFF};

	external_pin_interrupt_unit external_pin_interrupt_unit_i (.ref_clk(refClk), .nrst(nrst),
		.apbReq(req), .apbRsp(rsp), .extLineA(lines[0]), .extLineB(lines[1]),
		.pinChangeInputs(pins), .globalIntEnable(gie), .vectorTake(take), .irqRequest(irq),
		.vectorAck(ack), .wakeRequest(wake));
	core_vector_model core_vector_model_i (.ref_clk(refClk), .nrst(nrst), .en(coreEn),
		.delay(delay), .irqRequest(irq), .vectorTake(take));

	always #10 refClk = ~refClk;
	always @(posedge refClk) begin
		nAck += $countones(ack);
		nWake += int'(wake);
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checkCount++;
		if (s !== e) begin
			nFail++;
			$display("MISMATCH %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	task automatic finalReport();
		if (nFail == 0 && checkCount > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge refClk);
	endtask
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge refClk);
		req <= {1'b1, 1'b0, w, a, 24'h000000, d};
		@(posedge refClk);
		req.penable <= 1'b1;
		do begin
			@(posedge refClk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		if (n == 20) begin
			nFail++;
			finalReport();
		end
		v = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
	endtask

	initial begin
		cyc(10);
		nrst <= 1'b1;
		cyc(3);
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, MAP[i], 8'h00);
			chk("reset", 0, v);
			chk("error", 0, er);
			apb(1'b1, MAP[i], 8'hFF);
			apb(1'b0, MAP[i], 8'h00);
			chk("rw bits", RW[i], v);
			apb(1'b1, MAP[i], 8'h00);
		end
		apb(1'b0, 12'h000, 8'h00);
		chk("unmapped", 1, er);
		gie <= 1'b1;
		for (int l = 0; l < 2; l++) begin
			apb(1'b1, ADDR_LINE_ENABLE, 8'h01 << l);
			for (int m = 0; m < 4; m++) begin
				apb(1'b1, ADDR_SENSE_CONFIG, 8'(m << (2 * l)));
				apb(1'b1, ADDR_EXT_FLAG, 8'h03);
				for (int s = 0; s < 2; s++) begin
					lines[l] <= s[0]; // held six cycles
					cyc(6);
					ex = m == 1 || (m == 3 ? s[0] : !s[0]);
					chk("line req", ex, irq[l]);
					chk("other req", 0, irq[1 - l]);
					apb(1'b0, ADDR_EXT_FLAG, 8'h00);
					chk("line flag", m != 0 && ex, v[l]);
					apb(1'b1, ADDR_EXT_FLAG, 8'h03);
					cyc(4);
					chk("level", m == 0 && s == 0, irq[l]);
				end
			end
		end
		apb(1'b1, ADDR_LINE_ENABLE, 8'h01);
		apb(1'b1, ADDR_SENSE_CONFIG, 8'h03);
		gie <= 1'b0;
		lines[0] <= 1'b0;
		cyc(3);
		lines[0] <= 1'b1;
		cyc(6);
		chk("gated", 0, irq[0]);
		a0 = nAck;
		coreEn <= 1'b1;
		gie <= 1'b1;
		cyc(8);
		chk("taken", 1, nAck - a0);
		chk("cleared", 0, irq);
		apb(1'b1, ADDR_GROUP_ENABLE, 8'h07);
		delay <= 8'h05;
		for (int i = 0; i < 12; i++) begin
			seed = xs(seed);
			g = i % 3;
			p = int'(seed[2:0]);
			mk = seed[15:8];
			apb(1'b1, MAP[5 + g], mk);
			apb(1'b0, MAP[5 + g], 8'h00);
			chk("mask", g == 1 ? mk & 8'h7F : mk, v);
			a0 = nAck;
			w0 = nWake;
			pins[8 * g + p] <= ~pins[8 * g + p];
			cyc(16);
			ex = mk[p] && !(g == 1 && p == 7);
			chk("group", ex, nAck - a0);
			chk("wake", ex, nWake > w0);
		end
		finalReport();
	end
endmodule // tb_external_pin_interrupt_unit
`default_nettype wire
